// File: rtl/ooc_params.svh
// Offsets, field positions, reset values for the output control block
`ifndef OOC_PARAMS_SVH
`define OOC_PARAMS_SVH

`define OOC_CODE_OUTPUT_CONTROL 8'h01
`define OOC_CODE_MARGIN_HIGH 8'hD5
`define OOC_CODE_MARGIN_LOW 8'hD6
`define OOC_CODE_OVUV_PCT 8'hD7
`define OOC_CODE_USER_OPTIONS 8'hE5
`define OOC_CODE_MISC_OPTIONS 8'hF0

`define OOC_ON_BIT 7
`define OOC_OFF_BIT 6
`define OOC_MARGIN_MSB 5
`define OOC_MARGIN_LSB 2
`define OOC_CTRL_WR_MASK 8'hFC

`define OOC_CFG_PU_BIT 4
`define OOC_CFG_CMD_BIT 3
`define OOC_CFG_CPR_BIT 2
`define OOC_CFG_POL_BIT 1
`define OOC_CFG_CPA_BIT 0

`define OOC_RST_OUTPUT_CONTROL 8'h00
`define OOC_RST_HIGH_STEP_0 16'h0009
`define OOC_RST_HIGH_STEP_1 16'h000F
`define OOC_RST_LOW_STEP_0 16'hFFF7
`define OOC_RST_LOW_STEP_1 16'hFFF1
`define OOC_RST_OVUV_PCT 8'h00
`define OOC_RST_USER_OPTIONS 16'h0084
`define OOC_RST_MISC_OPTIONS 16'h0013

`define OOC_MARGIN_OFF_IGNORE 4'h1
`define OOC_MARGIN_LOW_IGNORE 4'h5
`define OOC_MARGIN_LOW_ACT 4'h6
`define OOC_MARGIN_HIGH_IGNORE 4'h9
`define OOC_MARGIN_HIGH_ACT 4'hA

`define OOC_PCT_UV_FAULT (-17)
`define OOC_PCT_UV_WARN (-12)
`define OOC_PCT_OV_WARN 12
`define OOC_PCT_OV_FAULT 17
`define OOC_PCT_DIVISOR 100

`endif

// File: rtl/ooc_pkg.sv
// Types shared by the output control block
package ooc_pkg;

    typedef enum logic [2:0] {
        OOC_REF_NOMINAL = 3'b001,
        OOC_REF_LOW = 3'b010,
        OOC_REF_HIGH = 3'b100
    } ooc_ref_sel_t;

    typedef enum logic [2:0] {
        OOC_ST_OFF = 3'b001,
        OOC_ST_RUN = 3'b010,
        OOC_ST_SOFT_STOP = 3'b100
    } ooc_state_t;

    typedef struct packed {
        logic ov_fault;
        logic uv_fault;
        logic cml;
        logic invalid_data;
        logic invalid_cmd;
    } ooc_status_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } ooc_cmd_t;

    typedef struct packed {
        logic valid;
        logic nack;
        logic [15:0] data;
    } ooc_rsp_t;

    typedef struct packed {
        logic [15:0] uv_fault;
        logic [15:0] uv_warn;
        logic [15:0] ov_warn;
        logic [15:0] ov_fault;
    } ooc_limits_t;

endpackage : ooc_pkg

// File: rtl/ooc_top.sv
// Output on/off and margin command logic of a PMBus converter target
`timescale 1ns/1ps
`include "ooc_params.svh"

module ooc_top
    import ooc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire ooc_cmd_t cmd_in,
    output ooc_rsp_t rsp_out,
    input wire logic high_step_select_in,
    input wire logic low_step_select_in,
    input wire logic loop_slave_in,
    input wire logic [4:0] on_off_config_in,
    input wire logic control_pin_in,
    input wire logic input_above_uvlo_in,
    input wire logic fault_present_in,
    input wire logic soft_stop_done_in,
    input wire logic [15:0] vout_command_in,
    input wire logic [15:0] vref_trim_in,
    input wire logic [3:0] scale_shift_in,
    input wire logic overvoltage_fault_in,
    input wire logic undervoltage_fault_in,
    input wire logic ov_alert_mask_in,
    input wire logic uv_alert_mask_in,
    input wire logic clear_faults_in,
    output logic switching_enable_out,
    output logic drivers_off_out,
    output logic soft_stop_out,
    output ooc_ref_sel_t ref_select_out,
    output logic [15:0] error_amp_reference_out,
    output logic ovuv_response_en_out,
    output ooc_limits_t limits_out,
    output ooc_status_t status_out,
    output logic alert_out
);

    logic [7:0] ctrl_r;
    logic [15:0] high_step_r;
    logic [15:0] low_step_r;
    logic [7:0] pct_r;
    logic [15:0] user_opt_r;
    logic [15:0] misc_opt_r;
    logic slave_r;
    logic pin_r;
    ooc_state_t state_r;
    ooc_state_t state_nxt;
    ooc_status_t status_r;
    ooc_status_t status_nxt;
    logic alert_r;
    ooc_rsp_t rsp_r;
    ooc_ref_sel_t ref_r;
    logic [15:0] target_r;
    logic respond_r;

    // Command decode
    wire wr = cmd_in.valid && cmd_in.write;
    wire hit_ctrl = cmd_in.code == `OOC_CODE_OUTPUT_CONTROL;
    wire hit_high = cmd_in.code == `OOC_CODE_MARGIN_HIGH;
    wire hit_low = cmd_in.code == `OOC_CODE_MARGIN_LOW;
    wire hit_pct = cmd_in.code == `OOC_CODE_OVUV_PCT;
    wire hit_uopt = cmd_in.code == `OOC_CODE_USER_OPTIONS;
    wire hit_misc = cmd_in.code == `OOC_CODE_MISC_OPTIONS;
    wire hit_any = hit_ctrl | hit_high | hit_low | hit_pct | hit_uopt
        | hit_misc;
    wire slave_ctrl = cmd_in.valid && hit_ctrl && slave_r;

    wire [7:0] wr_byte = cmd_in.data[7:0];
    wire [3:0] wr_margin = wr_byte[`OOC_MARGIN_MSB:`OOC_MARGIN_LSB];
    wire margin_ok = (wr_margin[3:2] == 2'b00)
        || (wr_margin == `OOC_MARGIN_LOW_IGNORE)
        || (wr_margin == `OOC_MARGIN_LOW_ACT)
        || (wr_margin == `OOC_MARGIN_HIGH_IGNORE)
        || (wr_margin == `OOC_MARGIN_HIGH_ACT);
    wire on_off_both = wr_byte[`OOC_ON_BIT] && wr_byte[`OOC_OFF_BIT];
    // Everything outside the accepted list is invalid, including 11XX
    wire ctrl_bad = on_off_both || !margin_ok;
    wire ctrl_wr_bad = wr && hit_ctrl && !slave_r && ctrl_bad;
    wire ctrl_wr_ok = wr && hit_ctrl && !slave_r && !ctrl_bad;

    // Read-only low bits always read as zero
    wire [7:0] ctrl_nxt = wr_byte & `OOC_CTRL_WR_MASK;

    // Mode decode from the held control register
    wire on_bit = ctrl_r[`OOC_ON_BIT];
    wire off_soft = ctrl_r[`OOC_OFF_BIT];
    wire [3:0] margin = ctrl_r[`OOC_MARGIN_MSB:`OOC_MARGIN_LSB];
    wire sel_low = margin == `OOC_MARGIN_LOW_IGNORE
        || margin == `OOC_MARGIN_LOW_ACT;
    wire sel_high = margin == `OOC_MARGIN_HIGH_IGNORE
        || margin == `OOC_MARGIN_HIGH_ACT;
    wire ignore_faults = margin == `OOC_MARGIN_OFF_IGNORE
        || margin == `OOC_MARGIN_LOW_IGNORE
        || margin == `OOC_MARGIN_HIGH_IGNORE;
    wire ooc_ref_sel_t ref_nxt = sel_high ? OOC_REF_HIGH
        : (sel_low ? OOC_REF_LOW : OOC_REF_NOMINAL);

    // Reference arithmetic; scale is a power of two shift
    wire signed [17:0] trim_s = {{2{vref_trim_in[15]}}, vref_trim_in};
    wire signed [17:0] low_s = {{2{low_step_r[15]}}, low_step_r};
    wire signed [17:0] high_s = {{2{high_step_r[15]}}, high_step_r};
    wire signed [17:0] low_off = (trim_s - low_s) >>> scale_shift_in;
    wire signed [17:0] high_off = (trim_s + high_s) >>> scale_shift_in;
    wire [15:0] low_tgt = vout_command_in + low_off[15:0];
    wire [15:0] high_tgt = vout_command_in + high_off[15:0];
    wire [15:0] target_nxt = sel_high ? high_tgt
        : (sel_low ? low_tgt : vout_command_in);

    // Output gating from the on/off configuration
    wire cfg_pu = on_off_config_in[`OOC_CFG_PU_BIT];
    wire cfg_cmd = on_off_config_in[`OOC_CFG_CMD_BIT];
    wire cfg_cpr = on_off_config_in[`OOC_CFG_CPR_BIT];
    wire cfg_pol = on_off_config_in[`OOC_CFG_POL_BIT];
    wire cfg_cpa = on_off_config_in[`OOC_CFG_CPA_BIT];
    wire pin_active = control_pin_in ~^ cfg_pol;
    wire cmd_gate = !cfg_cmd || on_bit;
    wire pin_gate = !cfg_cpr || pin_active;
    wire any_gate = cfg_cmd || cfg_cpr;
    // Without pu the output runs whenever input is above UVLO and no fault is present
    wire want_on = !cfg_pu || (any_gate && cmd_gate && pin_gate);
    wire may_run = input_above_uvlo_in && !fault_present_in;
    wire run_ok = want_on && may_run;
    // Pin-caused stop follows cpa, command-caused stop follows off bit
    wire cmd_stop = cfg_cmd && !on_bit;
    wire soft_req = cmd_stop ? off_soft : !cfg_cpa;
    wire pin_changed = control_pin_in != pin_r;

    // Status and alert events; set wins over clear
    wire ov_alert = overvoltage_fault_in && !ov_alert_mask_in;
    wire uv_alert = undervoltage_fault_in && !uv_alert_mask_in;
    wire alert_set = ov_alert || uv_alert || ctrl_wr_bad || slave_ctrl;

    always_comb begin
        status_nxt = clear_faults_in ? '0 : status_r;
        if (overvoltage_fault_in) begin
            status_nxt.ov_fault = 1'b1;
        end
        if (undervoltage_fault_in) begin
            status_nxt.uv_fault = 1'b1;
        end
        if (ctrl_wr_bad) begin
            status_nxt.cml = 1'b1;
            status_nxt.invalid_data = 1'b1;
        end
        if (slave_ctrl) begin
            status_nxt.cml = 1'b1;
            status_nxt.invalid_cmd = 1'b1;
        end
    end

    always_comb begin
        case (state_r)
            OOC_ST_OFF: begin
                state_nxt = run_ok ? OOC_ST_RUN : OOC_ST_OFF;
            end
            OOC_ST_RUN: begin
                if (!may_run) begin
                    state_nxt = OOC_ST_OFF;
                end else if (!want_on) begin
                    state_nxt = soft_req ? OOC_ST_SOFT_STOP : OOC_ST_OFF;
                end else begin
                    state_nxt = OOC_ST_RUN;
                end
            end
            OOC_ST_SOFT_STOP: begin
                if (!may_run || soft_stop_done_in) begin
                    state_nxt = OOC_ST_OFF;
                end else if (cmd_stop && !off_soft) begin
                    // A hard off cuts short a soft stop in progress
                    state_nxt = OOC_ST_OFF;
                end else if (run_ok) begin
                    state_nxt = OOC_ST_RUN;
                end else begin
                    state_nxt = OOC_ST_SOFT_STOP;
                end
            end
            default: begin
                state_nxt = OOC_ST_OFF;
            end
        endcase
    end

    // Register read data, low bits of narrower registers
    logic [15:0] rd_data;
    always_comb begin
        case (1'b1)
            hit_ctrl: rd_data = {8'h00, ctrl_r};
            hit_high: rd_data = high_step_r;
            hit_low: rd_data = low_step_r;
            hit_pct: rd_data = {8'h00, pct_r};
            hit_uopt: rd_data = user_opt_r;
            hit_misc: rd_data = misc_opt_r;
            default: rd_data = 16'h0000;
        endcase
    end

    // Strap levels caught while reset is held, so no async capture
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            slave_r <= loop_slave_in;
            high_step_r <= high_step_select_in ? `OOC_RST_HIGH_STEP_1
                : `OOC_RST_HIGH_STEP_0;
            low_step_r <= low_step_select_in ? `OOC_RST_LOW_STEP_1
                : `OOC_RST_LOW_STEP_0;
        end else begin
            if (wr && hit_high) begin
                high_step_r <= cmd_in.data;
            end
            if (wr && hit_low) begin
                low_step_r <= cmd_in.data;
            end
        end
    end

    // Rejected control writes leave the register as it was
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ctrl_r <= `OOC_RST_OUTPUT_CONTROL;
            pct_r <= `OOC_RST_OVUV_PCT;
            user_opt_r <= `OOC_RST_USER_OPTIONS;
            misc_opt_r <= `OOC_RST_MISC_OPTIONS;
        end else begin
            if (ctrl_wr_ok) begin
                ctrl_r <= ctrl_nxt;
            end
            if (wr && hit_pct) begin
                pct_r <= cmd_in.data[7:0];
            end
            if (wr && hit_uopt) begin
                user_opt_r <= cmd_in.data;
            end
            if (wr && hit_misc) begin
                misc_opt_r <= cmd_in.data;
            end
        end
    end

    // A fault event in the clear cycle wins over the clear
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_r <= OOC_ST_OFF;
            pin_r <= 1'b0;
            status_r <= '0;
            alert_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pin_r <= control_pin_in;
            status_r <= status_nxt;
            alert_r <= alert_set || (alert_r && !clear_faults_in);
        end
    end

    // Unknown codes and slave access to control are refused
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= cmd_in.valid;
            rsp_r.nack <= cmd_in.valid && (!hit_any || slave_ctrl);
            rsp_r.data <= (cmd_in.valid && !cmd_in.write && !slave_ctrl)
                ? rd_data : 16'h0000;
        end
    end

    // Mode outputs trail the held register by one cycle
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ref_r <= OOC_REF_NOMINAL;
            target_r <= 16'h0000;
            respond_r <= 1'b1;
        end else begin
            ref_r <= ref_nxt;
            target_r <= target_nxt;
            respond_r <= !ignore_faults;
        end
    end

    // Limits around nominal; codes other than 00h keep the same table
    localparam int PCT [4] = '{`OOC_PCT_UV_FAULT, `OOC_PCT_UV_WARN,
        `OOC_PCT_OV_WARN, `OOC_PCT_OV_FAULT};
    logic [15:0] lim_r [4];
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lim
            wire signed [31:0] nom = {16'h0000, vout_command_in};
            wire signed [31:0] delta = (nom * PCT[gi]) / `OOC_PCT_DIVISOR;
            wire signed [31:0] lim = nom + delta;
            always_ff @(posedge core_clk_in) begin
                if (reset_in) begin
                    lim_r[gi] <= 16'h0000;
                end else begin
                    lim_r[gi] <= lim[15:0];
                end
            end
        end
    endgenerate

    assign limits_out.uv_fault = lim_r[0];
    assign limits_out.uv_warn = lim_r[1];
    assign limits_out.ov_warn = lim_r[2];
    assign limits_out.ov_fault = lim_r[3];

    assign rsp_out = rsp_r;
    // Drivers off only in the off state, not during soft stop
    assign switching_enable_out = state_r == OOC_ST_RUN;
    assign drivers_off_out = state_r == OOC_ST_OFF;
    assign soft_stop_out = state_r == OOC_ST_SOFT_STOP;
    assign ref_select_out = ref_r;
    assign error_amp_reference_out = target_r;
    assign ovuv_response_en_out = respond_r;
    assign status_out = status_r;
    assign alert_out = alert_r;

    // Pin change is already folded into want_on each cycle
    wire unused_ok = pin_changed;

endmodule : ooc_top

// File: dv/ooc_host.sv
// Host model issuing decoded commands to the output control block
`timescale 1ns/1ps
module ooc_host
    import ooc_pkg::*;
(
    input wire logic core_clk_in,
    input wire ooc_rsp_t rsp_in,
    output ooc_cmd_t cmd_out
);
    initial cmd_out = '0;

    // Idle fields carry inverted data so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] code,
            input logic [15:0] d, output ooc_rsp_t r);
        @(negedge core_clk_in);
        cmd_out = '{1'h1, wr, code, d};
        @(negedge core_clk_in);
        cmd_out = '{1'h0, ~wr, ~code, ~d};
        r = rsp_in;
    endtask : xfer
endmodule : ooc_host

// File: dv/ooc_monitor.sv
// Assertion checker bound to the output control top
`timescale 1ns/1ps
`include "ooc_params.svh"
module ooc_monitor
    import ooc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire ooc_cmd_t cmd_in,
    input wire ooc_rsp_t rsp_out,
    input wire logic loop_slave_in,
    input wire logic [4:0] on_off_config_in,
    input wire logic input_above_uvlo_in,
    input wire logic fault_present_in,
    input wire logic overvoltage_fault_in,
    input wire logic undervoltage_fault_in,
    input wire logic ov_alert_mask_in,
    input wire logic uv_alert_mask_in,
    input wire logic switching_enable_out,
    input wire logic drivers_off_out,
    input wire logic soft_stop_out,
    input wire ooc_ref_sel_t ref_select_out,
    input wire logic ovuv_response_en_out,
    input wire ooc_status_t status_out,
    input wire logic alert_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    wire logic ctl_wr = cmd_in.valid && cmd_in.write && !loop_slave_in &&
        cmd_in.code == `OOC_CODE_OUTPUT_CONTROL;
    wire logic [3:0] mg = cmd_in.data[5:2];
    wire logic mg_bad = mg[3:2] == 2'h3 || mg == 4'h4 || mg == 4'h7 ||
        mg == 4'h8 || mg == 4'hB;
    // Only writes that can take effect on the on bit
    wire logic gate = on_off_config_in[4:3] == 2'h3 && !mg_bad;

    a_off_at_once: assert property (
        ctl_wr && gate && cmd_in.data[7:6] == 2'h0 |-> ##2 drivers_off_out)
        else $error("immediate stop not seen");
    a_soft_stop: assert property (
        ctl_wr && gate && cmd_in.data[7:6] == 2'h1 && switching_enable_out
        |-> ##2 soft_stop_out) else $error("soft stop not seen");
    a_start_gated: assert property (
        $rose(switching_enable_out) |->
        $past(input_above_uvlo_in) && !$past(fault_present_in))
        else $error("switching started without gates");
    a_both_bits_bad: assert property (
        ctl_wr && cmd_in.data[7:6] == 2'h3 |=>
        status_out.cml && status_out.invalid_data && alert_out)
        else $error("on and off together not flagged");
    a_margin_refused: assert property (
        ctl_wr && mg_bad |=> status_out.invalid_data && alert_out)
        else $error("bad margin code not flagged");
    a_slave_refused: assert property (
        cmd_in.valid && loop_slave_in &&
        cmd_in.code == `OOC_CODE_OUTPUT_CONTROL |=>
        rsp_out.nack && status_out.invalid_cmd && alert_out)
        else $error("loop slave access not refused");
    a_ov_flagged: assert property (
        overvoltage_fault_in && !ov_alert_mask_in |=>
        status_out.ov_fault && alert_out) else $error("ov event lost");
    a_uv_flagged: assert property (
        undervoltage_fault_in |=> status_out.uv_fault &&
        (alert_out || $past(uv_alert_mask_in))) else $error("uv event lost");
    a_low_ignore: assert property (
        ctl_wr && mg == 4'h5 && cmd_in.data[7:6] != 2'h3 |-> ##2
        ref_select_out == OOC_REF_LOW && !ovuv_response_en_out)
        else $error("margin low ignore mode wrong");
    a_high_act: assert property (
        ctl_wr && mg == 4'hA && cmd_in.data[7:6] != 2'h3 |-> ##2
        ref_select_out == OOC_REF_HIGH && ovuv_response_en_out)
        else $error("margin high act mode wrong");
endmodule : ooc_monitor

bind ooc_top ooc_monitor i_mon (.core_clk_in, .reset_in, .cmd_in, .rsp_out,
    .loop_slave_in, .on_off_config_in, .input_above_uvlo_in,
    .fault_present_in, .overvoltage_fault_in, .undervoltage_fault_in,
    .ov_alert_mask_in, .uv_alert_mask_in, .switching_enable_out,
    .drivers_off_out, .soft_stop_out, .ref_select_out, .ovuv_response_en_out,
    .status_out, .alert_out);

// File: dv/output_on_off_margin_control_test.sv
// Directed bench for the output control block
`timescale 1ns/1ps
`include "ooc_params.svh"
module output_on_off_margin_control_test;
    import ooc_pkg::*;
    logic core_clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic high_step_select_in, low_step_select_in, loop_slave_in;
    logic control_pin_in, input_above_uvlo_in, fault_present_in;
    logic soft_stop_done_in, overvoltage_fault_in, undervoltage_fault_in;
    logic ov_alert_mask_in, uv_alert_mask_in, clear_faults_in;
    logic [4:0] on_off_config_in;
    logic [3:0] scale_shift_in;
    logic [15:0] vout_command_in, vref_trim_in, error_amp_reference_out;
    logic switching_enable_out, drivers_off_out, soft_stop_out;
    logic ovuv_response_en_out, alert_out;
    ooc_cmd_t cmd_in;
    ooc_rsp_t rsp_out, r;
    ooc_ref_sel_t ref_select_out;
    ooc_limits_t limits_out;
    ooc_status_t status_out;
    int fail_count = 0;
    int samples_checked = 0;

    always #4 core_clk_in = ~core_clk_in;

    ooc_top i_dut (.core_clk_in, .reset_in, .cmd_in, .rsp_out,
        .high_step_select_in, .low_step_select_in, .loop_slave_in,
        .on_off_config_in, .control_pin_in, .input_above_uvlo_in,
        .fault_present_in, .soft_stop_done_in, .vout_command_in,
        .vref_trim_in, .scale_shift_in, .overvoltage_fault_in,
        .undervoltage_fault_in, .ov_alert_mask_in, .uv_alert_mask_in,
        .clear_faults_in, .switching_enable_out, .drivers_off_out,
        .soft_stop_out, .ref_select_out, .error_amp_reference_out,
        .ovuv_response_en_out, .limits_out, .status_out, .alert_out);
    ooc_host i_host (.core_clk_in, .rsp_in(rsp_out), .cmd_out(cmd_in));

    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_host.xfer(1'h1, c, d, r);
    endtask : wr

    task automatic rd(input string n, input logic [7:0] c, logic [15:0] e);
        i_host.xfer(1'h0, c, 16'h0000, r);
        chk("rsp valid", 1'h1, r.valid);
        chk(n, e, r.data);
    endtask : rd

    // Straps are only sampled while reset is high
    task automatic do_reset(input logic hs, ls, sl);
        @(negedge core_clk_in);
        reset_in = 1'h1;
        high_step_select_in = hs;
        low_step_select_in = ls;
        loop_slave_in = sl;
        cyc(3);
        reset_in = 1'h0;
    endtask : do_reset

    task automatic clr;
        @(negedge core_clk_in);
        clear_faults_in = 1'h1;
        cyc(1);
        clear_faults_in = 1'h0;
        cyc(1);
    endtask : clr

    task automatic pulse(input logic ov, uv);
        @(negedge core_clk_in);
        overvoltage_fault_in = ov;
        undervoltage_fault_in = uv;
        cyc(1);
        overvoltage_fault_in = 1'h0;
        undervoltage_fault_in = 1'h0;
        cyc(1);
    endtask : pulse

    function automatic logic [15:0] lim(input int p);
        return 16'(int'(vout_command_in) +
            int'(vout_command_in) * p / `OOC_PCT_DIVISOR);
    endfunction : lim

    task automatic t_defaults;
        do_reset(1'h0, 1'h0, 1'h0);
        rd("high step", 8'hD5, 16'h0009);
        rd("low step", 8'hD6, 16'hFFF7);
        rd("limit pct", 8'hD7, 16'h0000);
        rd("options", 8'hE5, 16'h0084);
        rd("misc", 8'hF0, 16'h0013);
        rd("control", 8'h01, 16'h0000);
        i_host.xfer(1'h0, 8'h55, 16'h0000, r);
        chk("unmapped nack", 1'h1, r.nack);
        chk("uv fault", lim(`OOC_PCT_UV_FAULT), limits_out.uv_fault);
        chk("uv warn", lim(`OOC_PCT_UV_WARN), limits_out.uv_warn);
        chk("ov warn", lim(`OOC_PCT_OV_WARN), limits_out.ov_warn);
        chk("ov fault", lim(`OOC_PCT_OV_FAULT), limits_out.ov_fault);
        do_reset(1'h1, 1'h1, 1'h0);
        rd("high step", 8'hD5, 16'h000F);
        rd("low step", 8'hD6, 16'hFFF1);
    endtask : t_defaults

    task automatic t_on_off;
        input_above_uvlo_in = 1'h0;
        wr(8'h01, 16'h0080);
        cyc(3);
        chk("run low uvlo", 1'h0, switching_enable_out);
        input_above_uvlo_in = 1'h1;
        cyc(3);
        chk("run", 1'h1, switching_enable_out);
        cyc(8);
        chk("run held", 1'h1, switching_enable_out);
        fault_present_in = 1'h1;
        cyc(2);
        chk("fault stop", 1'h0, switching_enable_out);
        fault_present_in = 1'h0;
        cyc(3);
        chk("rerun", 1'h1, switching_enable_out);
        wr(8'h01, 16'h0040);
        cyc(2);
        chk("soft stop", 1'h1, soft_stop_out);
        soft_stop_done_in = 1'h1;
        cyc(1);
        soft_stop_done_in = 1'h0;
        cyc(1);
        chk("off", 1'h1, drivers_off_out);
        wr(8'h01, 16'h0080);
        cyc(3);
        wr(8'h01, 16'h0000);
        cyc(2);
        chk("hard off", 1'h1, drivers_off_out);
        chk("no soft", 1'h0, soft_stop_out);
        on_off_config_in = 5'h12;
        wr(8'h01, 16'h0080);
        cyc(3);
        chk("on ignored", 1'h0, switching_enable_out);
        on_off_config_in = 5'h16;
        control_pin_in = 1'h1;
        cyc(3);
        chk("pin on", 1'h1, switching_enable_out);
        control_pin_in = 1'h0;
        cyc(2);
        chk("pin soft", 1'h1, soft_stop_out);
        soft_stop_done_in = 1'h1;
        cyc(1);
        soft_stop_done_in = 1'h0;
        on_off_config_in = 5'h12;
        cyc(1);
        chk("pin off", 1'h1, drivers_off_out);
    endtask : t_on_off

    task automatic t_margin;
        logic [15:0] d, prev, vs;
        logic ok, en;
        ooc_ref_sel_t er;
        vs = 16'h066F;
        prev = 16'h0000;
        er = OOC_REF_NOMINAL;
        en = 1'h1;
        wr(8'h01, prev);
        clr;
        for (int m = 0; m < 16; m++) begin
            ok = vs[m];
            d = {10'h000, m[3:0], 2'h3};
            wr(8'h01, d);
            cyc(2);
            if (ok) begin
                prev = d & 16'h00FC;
                er = m[3:0] inside {4'h5, 4'h6} ? OOC_REF_LOW :
                    m[3:0] inside {4'h9, 4'hA} ? OOC_REF_HIGH : OOC_REF_NOMINAL;
                en = !(m[3:0] inside {4'h1, 4'h5, 4'h9});
            end
            rd("control", 8'h01, prev);
            chk("ivd", !ok, status_out.invalid_data);
            chk("alert", !ok, alert_out);
            chk("ref", er, ref_select_out);
            chk("resp", en, ovuv_response_en_out);
            clr;
        end
        wr(8'h01, 16'h00C0);
        cyc(1);
        chk("cml", 1'h1, status_out.cml);
        chk("ivd", 1'h1, status_out.invalid_data);
        chk("alert", 1'h1, alert_out);
        rd("control", 8'h01, prev);
        clr;
    endtask : t_margin

    task automatic t_target;
        vref_trim_in = 16'h0007;
        scale_shift_in = 4'h1;
        wr(8'hD5, 16'h0003);
        rd("high step", 8'hD5, 16'h0003);
        wr(8'h01, 16'h0028);
        cyc(2);
        chk("high ref", vout_command_in + ((vref_trim_in + 16'h0003) >>
            scale_shift_in), error_amp_reference_out);
        wr(8'h01, 16'h0018);
        cyc(2);
        chk("low ref", vout_command_in + ((vref_trim_in - 16'hFFF1) >>
            scale_shift_in), error_amp_reference_out);
    endtask : t_target

    task automatic t_faults;
        wr(8'h01, 16'h0024);
        pulse(1'h1, 1'h0);
        chk("ov status", 1'h1, status_out.ov_fault);
        chk("ov alert", 1'h1, alert_out);
        clr;
        wr(8'h01, 16'h0014);
        uv_alert_mask_in = 1'h1;
        pulse(1'h0, 1'h1);
        chk("uv status", 1'h1, status_out.uv_fault);
        chk("uv masked", 1'h0, alert_out);
        clr;
        uv_alert_mask_in = 1'h0;
        wr(8'h01, 16'h0004);
        pulse(1'h1, 1'h1);
        chk("both status", 5'h18, status_out);
        chk("both alert", 1'h1, alert_out);
        clr;
    endtask : t_faults

    task automatic t_slave;
        do_reset(1'h1, 1'h1, 1'h1);
        i_host.xfer(1'h1, 8'h01, 16'h0080, r);
        chk("nack", 1'h1, r.nack);
        cyc(1);
        chk("ivc", 1'h1, status_out.invalid_cmd);
        chk("alert", 1'h1, alert_out);
        i_host.xfer(1'h0, 8'h01, 16'h0000, r);
        chk("read nack", 1'h1, r.nack);
    endtask : t_slave

    initial begin
        {high_step_select_in, low_step_select_in, loop_slave_in,
            control_pin_in, fault_present_in, soft_stop_done_in,
            overvoltage_fault_in, undervoltage_fault_in, ov_alert_mask_in,
            uv_alert_mask_in, clear_faults_in, vref_trim_in,
            scale_shift_in} = '0;
        input_above_uvlo_in = 1'h1;
        on_off_config_in = 5'h1A;
        vout_command_in = 16'h03E8;
        t_defaults;
        t_on_off;
        t_margin;
        t_target;
        t_faults;
        t_slave;
        stop_test;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        stop_test;
    end
endmodule : output_on_off_margin_control_test
